/* File: rtl/setwp_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module setwp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  // Clock and synchronous reset.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] mem_next [DEPTH];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != CW'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer, count and storage updates; flush empties the buffer.
  always_comb
  begin
    mem_next = mem_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (flush)
    begin
      wp_next = '0;
      rp_next = '0;
      cnt_next = '0;
    end
    else
    begin
      if (push)
      begin
        mem_next[wp_reg] = in_data;
        wp_next = (wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop)
      begin
        rp_next = (rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_next = cnt_reg + CW'(push) - CW'(pop);
    end
  end

  // Registers only.
  always_ff @(posedge clk)
  begin
    mem_reg <= mem_next;
    if (!rst_n)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/setwp_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module setwp_mem #(
  parameter int WORDS = 1024,
  parameter int AW = 10
) (
  // Clock.
  input wire logic clk,
  // Access port.
  input wire logic wr,
  input wire logic rd,
  input wire logic [AW-1:0] addr,
  input wire logic [1:0] be,
  input wire logic [15:0] wdata,
  // Registered read data.
  output logic [15:0] rdata
);
  logic [15:0] cells [WORDS];

  // Byte-lane writes, and a read that lands in a register.
  always_ff @(posedge clk)
  begin
    if (wr && be[0])
    begin
      cells[addr][7:0] <= wdata[7:0];
    end
    if (wr && be[1])
    begin
      cells[addr][15:8] <= wdata[15:8];
    end
    if (rd)
    begin
      rdata <= cells[addr];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/setwp_pkg.sv */
package setwp_pkg;
  // Array geometry.
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int MEM_WORDS = 1024;
  localparam int WADDR_W = 10;
  localparam int ADDR_W = 11;
  // Instruction lengths in serial bits, start bit included.
  localparam int INSTR_BITS_X16 = 13;
  localparam int INSTR_BITS_X8 = 14;
  localparam logic [4:0] LAST_CMD_X16 = 5'(INSTR_BITS_X16 - 2);
  localparam logic [4:0] LAST_CMD_X8 = 5'(INSTR_BITS_X8 - 2);
  localparam logic [4:0] LAST_DATA_X16 = 5'(WORD_W - 1);
  localparam logic [4:0] LAST_DATA_X8 = 5'(BYTE_W - 1);
  // Opcodes and the extended selector carried in the top address bits.
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] EXT_UNLOCK = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_CLEAR_ALL = 2'h2;
  localparam logic [1:0] EXT_FILL_ALL = 2'h1;
  // Reset values and the erased pattern.
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
  localparam logic UNLOCK_RST = 1'b0;
  // Self-timed program cycle, longest time rounded down to cycles.
  localparam int CLOCK_HZ = 25000000;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES_DEF = PROG_TIME_MS * (CLOCK_HZ / 1000);
  // Serial front-end states.
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_CMD = 5'h02,
    S_DATA = 5'h04,
    S_READ = 5'h08,
    S_HOLD = 5'h10
  } setwp_ser_t;
  // Programming engine states.
  typedef enum logic [2:0] {
    PG_IDLE = 3'h1,
    PG_SWEEP = 3'h2,
    PG_WAIT = 3'h4
  } setwp_pg_t;
  // Kinds of self-timed job.
  typedef enum logic [1:0] {
    PK_WORD = 2'h0,
    PK_ERASE = 2'h1,
    PK_CLEAR_ALL = 2'h2,
    PK_FILL_ALL = 2'h3
  } setwp_kind_t;
  // A job handed from the serial front end to the engine.
  typedef struct packed {
    setwp_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } setwp_job_t;
  // One access to the array.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [WADDR_W-1:0] addr;
    logic [1:0] be;
    logic [WORD_W-1:0] wdata;
  } setwp_mem_req_t;
endpackage

/* File: rtl/setwp_top.sv */
`timescale 1ns/1ns
`default_nettype none
module setwp_top
  import setwp_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF,
  parameter int BUF_DEPTH = 2
) (
  // Clock and synchronous active-low reset.
  input wire logic CLOCK,
  input wire logic RST_N,
  // Serial link from the host.
  input wire logic SELECT_IN,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic SERIAL_DATA_IN,
  // Serial data back to the host, with its drive enable.
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OE,
  // Straps.
  input wire logic WORD_WIDTH_SELECT,
  input wire logic PROGRAM_PERMIT
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [TW-1:0] PROG_LAST = TW'(PROG_CYCLES - 1);
  localparam logic [WADDR_W-1:0] SWEEP_LAST = WADDR_W'(MEM_WORDS - 1);

  // Next address in the stream, wrapping at the end of the space.
  function automatic logic [ADDR_W-1:0] addr_step(
    input logic [ADDR_W-1:0] a,
    input logic wide
  );
    logic [ADDR_W-1:0] n;
    n = a + 11'h001;
    if (wide)
    begin
      n[ADDR_W-1] = 1'b0;
    end
    return n;
  endfunction

  logic sel_reg, sel_prev_reg, sk_reg, sk_prev_reg, di_reg;
  logic sk_rise, sk_fall, sel_fall, wide, prog_busy, in_read;
  setwp_ser_t st_reg, st_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [12:0] cmd_reg, cmd_next;
  logic [15:0] data_reg, data_next, shift_reg, shift_next;
  logic [4:0] left_reg, left_next;
  logic [ADDR_W-1:0] rd_addr_reg, rd_addr_next;
  logic unlock_reg, unlock_next, status_reg, status_next;
  logic rel_reg, rel_next, do_reg, do_next, oe_reg, oe_next;
  logic arm_reg, arm_next; // A complete job waits for select to fall.
  logic fetch_reg, fetch_next, fhi_reg, fhi_next, fwide_reg, fwide_next;
  setwp_job_t pend_reg, pend_next;
  logic prog_start;
  logic [1:0] opc, ext;
  logic [ADDR_W-1:0] adr;
  logic [4:0] last_cmd, last_data;
  setwp_pg_t pg_reg, pg_next;
  setwp_job_t job_reg, job_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic [WADDR_W-1:0] sweep_reg, sweep_next;
  setwp_mem_req_t mreq;
  logic [15:0] rdata;
  logic issue, f_in_ready, f_out_valid, pop;
  logic [15:0] f_in_data, f_out_data;

  // Pin sampling and edge detection; inputs are synchronous.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      sel_reg <= 1'b0;
      sel_prev_reg <= 1'b0;
      sk_reg <= 1'b0;
      sk_prev_reg <= 1'b0;
      di_reg <= 1'b0;
    end
    else
    begin
      sel_reg <= SELECT_IN;
      sel_prev_reg <= sel_reg;
      sk_reg <= SERIAL_CLOCK_IN;
      sk_prev_reg <= sk_reg;
      di_reg <= SERIAL_DATA_IN;
    end
  end

  assign sk_rise = sk_reg && !sk_prev_reg;
  assign sk_fall = !sk_reg && sk_prev_reg;
  assign sel_fall = sel_prev_reg && !sel_reg;
  assign wide = WORD_WIDTH_SELECT;
  assign prog_busy = (pg_reg != PG_IDLE);
  assign in_read = (st_reg == S_READ);
  assign last_cmd = wide ? LAST_CMD_X16 : LAST_CMD_X8;
  assign last_data = wide ? LAST_DATA_X16 : LAST_DATA_X8;
  assign SERIAL_DATA_OUT = do_reg;
  assign SERIAL_DATA_OE = oe_reg && sel_reg;

  // Field split of the command as it will stand after this bit.
  always_comb
  begin
    cmd_next = {cmd_reg[11:0], di_reg};
    opc = wide ? cmd_next[11:10] : cmd_next[12:11];
    adr = wide ? {1'b0, cmd_next[9:0]} : cmd_next[10:0];
    ext = wide ? cmd_next[9:8] : cmd_next[10:9];
  end

  // Serial front end: framing, decode, read streaming and status.
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    data_next = data_reg;
    shift_next = shift_reg;
    left_next = left_reg;
    rd_addr_next = rd_addr_reg;
    unlock_next = unlock_reg;
    pend_next = pend_reg;
    arm_next = arm_reg;
    rel_next = rel_reg;
    status_next = status_reg;
    pop = 1'b0;
    prog_start = 1'b0;
    if (rel_reg && sk_fall && sel_reg)
    begin
      status_next = 1'b0;
      rel_next = 1'b0;
    end
    if (sel_reg && !in_read && status_reg && sk_rise && di_reg)
    begin
      rel_next = 1'b1;
    end
    do_next = ~prog_busy;
    oe_next = status_next;
    if (!sel_reg)
    begin
      st_next = S_IDLE;
      cnt_next = 5'h00;
      rel_next = 1'b0;
      // Only a fully received program job may start the engine.
      arm_next = 1'b0;
      if (st_reg == S_HOLD && sel_fall && arm_reg)
      begin
        prog_start = unlock_reg && PROGRAM_PERMIT && !prog_busy;
      end
      if (prog_start)
      begin
        status_next = 1'b1;
      end
      oe_next = 1'b0;
    end
    else
    begin
      case (st_reg)
        S_IDLE:
        begin
          if (sk_rise && di_reg && !prog_busy)
          begin
            st_next = S_CMD;
            cnt_next = 5'h00;
          end
        end
        S_CMD:
        begin
          if (sk_rise)
          begin
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == last_cmd)
            begin
              st_next = S_HOLD;
              cnt_next = 5'h00;
              pend_next.addr = adr;
              if (opc == OPC_READ)
              begin
                st_next = S_READ;
                do_next = 1'b0;
                oe_next = 1'b1;
                left_next = 5'h00;
                rd_addr_next = adr;
              end
              else if (opc == OPC_WRITE)
              begin
                st_next = S_DATA;
                pend_next.kind = PK_WORD;
              end
              else if (opc == OPC_ERASE)
              begin
                pend_next.kind = PK_ERASE;
                arm_next = 1'b1;
              end
              else if (ext == EXT_FILL_ALL)
              begin
                st_next = S_DATA;
                pend_next.kind = PK_FILL_ALL;
              end
              else if (ext == EXT_CLEAR_ALL)
              begin
                pend_next.kind = PK_CLEAR_ALL;
                arm_next = 1'b1;
              end
              else
              begin
                unlock_next = (ext == EXT_UNLOCK);
                pend_next.addr = 11'h000;
              end
            end
          end
        end
        S_DATA:
        begin
          if (sk_rise)
          begin
            data_next = {data_reg[14:0], di_reg};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == last_data)
            begin
              st_next = S_HOLD;
              pend_next.data = data_next;
              arm_next = 1'b1;
            end
          end
        end
        S_READ:
        begin
          oe_next = 1'b1;
          do_next = do_reg;
          if (sk_rise && left_reg == 5'h00 && f_out_valid)
          begin
            pop = 1'b1;
            do_next = f_out_data[15];
            shift_next = {f_out_data[14:0], 1'b0};
            left_next = last_data;
          end
          else if (sk_rise && left_reg != 5'h00)
          begin
            do_next = shift_reg[15];
            shift_next = {shift_reg[14:0], 1'b0};
            left_next = left_reg - 5'h01;
          end
        end
        default:
        begin
          st_next = st_reg;
        end
      endcase
    end
    // The stream address moves on as each word is fetched.
    if (issue)
    begin
      rd_addr_next = addr_step(rd_addr_reg, wide);
    end
  end

  // Read prefetch into the buffer, stalled by its ready.
  assign issue = in_read && sel_reg && f_in_ready && !fetch_reg;
  always_comb
  begin
    fetch_next = issue;
    fhi_next = issue ? rd_addr_reg[0] : fhi_reg;
    fwide_next = issue ? wide : fwide_reg;
    if (fwide_reg)
    begin
      f_in_data = rdata;
    end
    else
    begin
      f_in_data = fhi_reg ? {rdata[15:8], 8'h00} : {rdata[7:0], 8'h00};
    end
  end

  // Programming engine: write the addressed word, or sweep the array for the all-word jobs, then run out the cycle timer.
  always_comb
  begin
    pg_next = pg_reg;
    job_next = job_reg;
    timer_next = timer_reg;
    sweep_next = sweep_reg;
    mreq = '0;
    mreq.rd = issue;
    mreq.addr = wide ? rd_addr_reg[9:0] : rd_addr_reg[10:1];
    case (pg_reg)
      PG_IDLE:
      begin
        if (prog_start)
        begin
          pg_next = PG_SWEEP;
          job_next = pend_reg;
          timer_next = '0;
          sweep_next = '0;
        end
      end
      PG_SWEEP:
      begin
        timer_next = timer_reg + 1'b1;
        mreq.rd = 1'b0;
        mreq.wr = 1'b1;
        mreq.be = 2'h3;
        mreq.addr = wide ? job_reg.addr[9:0] : job_reg.addr[10:1];
        mreq.wdata = wide ? job_reg.data : {2{job_reg.data[7:0]}};
        if (job_reg.kind == PK_ERASE || job_reg.kind == PK_CLEAR_ALL)
        begin
          mreq.wdata = ERASED_WORD;
        end
        if (job_reg.kind == PK_WORD || job_reg.kind == PK_ERASE)
        begin
          // In narrow mode only the addressed byte lane is written; no erase is done first.
          if (!wide)
          begin
            mreq.be = job_reg.addr[0] ? 2'h2 : 2'h1;
          end
          pg_next = PG_WAIT;
        end
        else
        begin
          mreq.addr = sweep_reg;
          sweep_next = sweep_reg + 1'b1;
          if (sweep_reg == SWEEP_LAST)
          begin
            pg_next = PG_WAIT;
          end
        end
      end
      PG_WAIT:
      begin
        timer_next = timer_reg + 1'b1;
        if (timer_reg >= PROG_LAST)
        begin
          pg_next = PG_IDLE;
        end
      end
      default:
      begin
        pg_next = PG_IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      st_reg <= S_IDLE;
      cnt_reg <= 5'h00;
      cmd_reg <= 13'h0000;
      data_reg <= 16'h0000;
      shift_reg <= 16'h0000;
      left_reg <= 5'h00;
      rd_addr_reg <= 11'h000;
      unlock_reg <= UNLOCK_RST;
      status_reg <= 1'b0;
      rel_reg <= 1'b0;
      arm_reg <= 1'b0;
      do_reg <= 1'b1;
      oe_reg <= 1'b0;
      fetch_reg <= 1'b0;
      fhi_reg <= 1'b0;
      fwide_reg <= 1'b1;
      pend_reg <= '0;
      pg_reg <= PG_IDLE;
      job_reg <= '0;
      timer_reg <= '0;
      sweep_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      cmd_reg <= (st_reg == S_CMD && sk_rise) ? cmd_next : cmd_reg;
      data_reg <= data_next;
      shift_reg <= shift_next;
      left_reg <= left_next;
      rd_addr_reg <= rd_addr_next;
      unlock_reg <= unlock_next;
      status_reg <= status_next;
      rel_reg <= rel_next;
      arm_reg <= arm_next;
      do_reg <= do_next;
      oe_reg <= oe_next;
      fetch_reg <= fetch_next && in_read;
      fhi_reg <= fhi_next;
      fwide_reg <= fwide_next;
      pend_reg <= pend_next;
      pg_reg <= pg_next;
      job_reg <= job_next;
      timer_reg <= timer_next;
      sweep_reg <= sweep_next;
    end
  end

  setwp_mem #(.WORDS(MEM_WORDS), .AW(WADDR_W)) u_mem (
    .clk(CLOCK), .wr(mreq.wr), .rd(mreq.rd), .addr(mreq.addr),
    .be(mreq.be), .wdata(mreq.wdata), .rdata(rdata)
  );

  setwp_fifo #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(CLOCK), .rst_n(RST_N), .flush(!in_read || !sel_reg),
    .in_valid(fetch_reg), .in_ready(f_in_ready), .in_data(f_in_data),
    .out_valid(f_out_valid), .out_ready(pop), .out_data(f_out_data)
  );

  // Checks on the link and the engine.
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  deselect_idle_a: assert property (!sel_reg |=> st_reg == S_IDLE)
    else $error("front end not idle after deselect");
  quiet_output_a: assert property ((sel_reg && st_reg == S_IDLE &&
    !status_reg) |-> !SERIAL_DATA_OE)
    else $error("output driven with nothing to show");
  busy_low_a: assert property ((SERIAL_DATA_OE && !in_read &&
    prog_busy && $past(prog_busy)) |-> !SERIAL_DATA_OUT)
    else $error("busy status not low");
  ready_high_a: assert property ((SERIAL_DATA_OE && !in_read &&
    !prog_busy && !$past(prog_busy)) |-> SERIAL_DATA_OUT)
    else $error("ready status not high");
  status_release_a: assert property ((rel_reg && sk_fall && sel_reg)
    |=> !SERIAL_DATA_OE)
    else $error("status not released at falling clock");
  dummy_zero_a: assert property ($rose(in_read) |->
    (SERIAL_DATA_OE && !SERIAL_DATA_OUT))
    else $error("read did not open with a zero");
  read_edge_a: assert property ((in_read && $past(in_read) &&
    $changed(do_reg)) |-> $past(sk_rise))
    else $error("read bit changed off the rising edge");
  permit_gate_a: assert property ($rose(prog_busy) |->
    ($past(unlock_reg) && $past(PROGRAM_PERMIT)))
    else $error("program cycle without permission");
  start_fall_a: assert property ($rose(prog_busy) |-> $past(sel_fall))
    else $error("program cycle not started by select falling");
  cycle_time_a: assert property ($fell(prog_busy) |->
    ($past(timer_reg) >= PROG_LAST))
    else $error("program cycle ended early");
  wrap_zero_a: assert property ((issue && wide &&
    rd_addr_reg == 11'h3ff) |=> rd_addr_reg == 11'h000)
    else $error("stream address did not wrap");

  read_seen_c: cover property ($rose(in_read) ##[1:400] pop);
  prog_done_c: cover property ($fell(prog_busy));
  release_c: cover property (rel_reg && sk_fall && sel_reg);
endmodule
`default_nettype wire

/* File: tb/setwp_host.sv */
`timescale 1ns/1ns
`default_nettype none
module setwp_host (
  // Clock.
  input wire logic clk,
  // Serial pins towards the device.
  output logic cs,
  output logic sk,
  output logic di,
  // Serial output back from the device.
  input wire logic dout
);
  logic rx;
  // Idle pins; the serial clock stands still between frames.
  initial
  begin
    cs = 1'b0;
    sk = 1'b0;
    di = 1'b0;
    rx = 1'b0;
  end
  // Select moves just after an edge and is then held for a while.
  task automatic sel(input logic v);
    @(posedge clk);
    #1 cs = v;
    repeat (5) @(posedge clk);
    #1;
  endtask
  // One bit: data set while low, output read late in the high phase.
  task automatic bit1(input logic b);
    @(posedge clk);
    #1 di = b;
    repeat (5) @(posedge clk);
    #1 sk = 1'b1;
    repeat (5) @(posedge clk);
    #1 rx = dout;
    sk = 1'b0;
  endtask
  // Sends the n low bits of v, most significant first.
  task automatic send(input int v, input int n);
    for (int i = n - 1; i >= 0; i--)
      bit1(v[i]);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_setwp_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_setwp_top
  import setwp_pkg::*;
;
  // ----------------------------------------
  // Bench, behavioural model and checks
  // ----------------------------------------
  localparam int PC = 2000;
  localparam int PUW = 25000; // One millisecond of clock cycles.
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wide = 1'b1;
  logic permit = 1'b1;
  wire sel, sk, di, dout, oe, line;
  int n_fail = 0;
  int checks_done = 0;
  logic [15:0] mem [1024];
  logic [31:0] lf = 32'hfb3f889c;
  logic [15:0] d;
  // Free-running clock of 40 ns.
  always #20 clock = ~clock;
  // A released output reads inverted, so a missing drive cannot pass.
  assign line = oe ? dout : ~dout;
  setwp_top #(.PROG_CYCLES(PC)) i_setwp_top (.CLOCK(clock), .RST_N(rst_n),
    .SELECT_IN(sel), .SERIAL_CLOCK_IN(sk), .SERIAL_DATA_IN(di),
    .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OE(oe),
    .WORD_WIDTH_SELECT(wide), .PROGRAM_PERMIT(permit));
  setwp_host i_setwp_host (.clk(clock), .cs(sel), .sk(sk), .di(di),
    .dout(line));
  // Compares one value and counts it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Next pseudo-random word.
  function automatic logic [15:0] rnd();
    lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h04c11db7 : 32'h0);
    return lf[15:0];
  endfunction
  // Expected word, or byte of the internal word in narrow mode.
  function automatic logic [15:0] ex(input int a);
    if (wide)
      return mem[a % 1024];
    return (a % 2 == 1) ? {8'h0, mem[(a % 2048) / 2][15:8]}
      : {8'h0, mem[(a % 2048) / 2][7:0]};
  endfunction
  // Start bit, opcode and address, width set by the organisation.
  task automatic cmd(input logic [1:0] op, input int a);
    if (wide)
      i_setwp_host.send((4 + op) * 1024 + a, 13);
    else
      i_setwp_host.send((4 + op) * 2048 + a, 14);
  endtask
  // Streams n units from address a and compares each one.
  task automatic rd(input int a, input int n);
    logic [15:0] w;
    i_setwp_host.sel(1'b1);
    i_setwp_host.bit1(1'b0);
    cmd(OPC_READ, a);
    chk(16'(oe), 16'h1);
    chk(16'(i_setwp_host.rx), 16'h0);
    for (int k = 0; k < n; k++)
    begin
      w = 16'h0;
      for (int b = 0; b < (wide ? 16 : 8); b++)
      begin
        i_setwp_host.bit1(1'b0);
        w = {w[14:0], i_setwp_host.rx};
      end
      chk(w, ex(a + k));
    end
    i_setwp_host.sel(1'b0);
    chk(16'(oe), 16'h0);
  endtask
  // Programming job with status polling when it should run.
  task automatic prog(input logic [1:0] op, input int a,
    input logic [15:0] dv, input bit ok);
    int n;
    n = 0;
    i_setwp_host.sel(1'b1);
    cmd(op, a);
    if (op == OPC_WRITE || (op == OPC_EXT && a == 'h100))
      i_setwp_host.send(dv, wide ? 16 : 8);
    i_setwp_host.sel(1'b0);
    i_setwp_host.sel(1'b1);
    chk(16'(oe), 16'(ok));
    if (ok)
    begin
      chk(16'(line), 16'h0);
      while (line !== 1'b1 && n < PC + 100)
      begin
        @(posedge clock);
        #1 n++;
      end
      chk(16'(n < PC && n > PC / 2), 16'h1);
      i_setwp_host.bit1(1'b1);
      repeat (4) @(posedge clock);
      #1 chk(16'(oe), 16'h0);
      if (op == OPC_WRITE && !wide)
        mem[a / 2][(a % 2) * 8 +: 8] = dv[7:0];
      else if (op == OPC_WRITE)
        mem[a] = dv;
      else if (op == OPC_ERASE)
        mem[a] = ERASED_WORD;
      else
        foreach (mem[i])
          mem[i] = (a == 'h100) ? dv : ERASED_WORD;
    end
    i_setwp_host.sel(1'b0);
  endtask
  // Main sequence.
  initial
  begin
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (PUW) @(posedge clock);
    prog(OPC_EXT, 'h200, 16'h0, 1'b0);
    i_setwp_host.sel(1'b1);
    cmd(OPC_EXT, 'h300);
    i_setwp_host.sel(1'b0);
    prog(OPC_EXT, 'h200, 16'h0, 1'b1);
    d = rnd();
    prog(OPC_EXT, 'h100, d, 1'b1);
    rd(5, 1);
    for (int i = 0; i < 3; i++)
    begin
      d = rnd();
      prog(OPC_WRITE, (i + 1023) % 1024, d, 1'b1);
    end
    prog(OPC_ERASE, 0, 16'h0, 1'b1);
    rd(1022, 4);
    permit = 1'b0;
    prog(OPC_WRITE, 1, 16'h1234, 1'b0);
    i_setwp_host.sel(1'b1);
    cmd(OPC_EXT, 'h000);
    i_setwp_host.sel(1'b0);
    permit = 1'b1;
    prog(OPC_WRITE, 1, 16'h4321, 1'b0);
    rd(1, 1);
    wide = 1'b0;
    rd(2047, 3);
    // Byte write in narrow mode after an unlock, then noise while idle.
    i_setwp_host.sel(1'b1);
    cmd(OPC_EXT, 'h600);
    i_setwp_host.sel(1'b0);
    d = rnd();
    prog(OPC_WRITE, 2047, d, 1'b1);
    i_setwp_host.send(rnd(), 16);
    chk(16'(oe), 16'h0);
    rd(2046, 2);
    // A reset in mid-run locks the device again.
    rst_n = 1'b0;
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    prog(OPC_WRITE, 2046, {8'h00, ~mem[1023][7:0]}, 1'b0);
    rd(2046, 1);
    report_and_stop();
  end
  // Watchdog against a hang.
  initial
  begin
    #(40 * 90000);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
